/* mdc_cmd_handler.sv */
// Task-file command interpreter for microcode download, diagnostic and flush
`timescale 1ns/1ns
`default_nettype none
module mdc_cmd_handler
    import mdc_pkg::*;
#(
    parameter int IMAGE_SECTORS = 1024
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Sector data stream from the host link
    input  wire logic        dataValid,
    input  wire logic [31:0] dataWord,
    output logic             dataReady,
    // Device-side status and engines
    input  wire logic        securityLocked,
    input  wire logic        spinupDisabled,
    input  wire logic        softReset,
    input  wire logic        lastSegment,
    input  wire logic        reloadRequested,
    input  wire logic        verifyDone,
    input  wire logic        verifyOk,
    input  wire logic        reloadDone,
    input  wire logic        reloadOk,
    input  wire logic        diagDone,
    input  wire logic [7:0]  diagCode,
    input  wire logic        cacheEmpty,
    output logic             imageDiscard,
    output logic             imageSave,
    output logic             reloadStart,
    output logic             diagStart,
    output logic             flushStart,
    output logic             spinDown,
    output logic             firmwareActive
);
    // Refuse image sizes outside 1 to 65536 sectors
    if (IMAGE_SECTORS < 1 || IMAGE_SECTORS > 65536) begin : gBadImage
        $error("IMAGE_SECTORS out of range");
    end

    typedef enum {S_IDLE, S_XFER, S_VERIFY, S_RELOAD, S_DIAG, S_FLUSH} mdc_state_t;
    mdc_state_t state_r;

    logic [7:0]  featR, secCntR, secNumR, cylLoR, cylHiR;
    logic [7:0]  errR, statusR;
    logic [15:0] xferLen, segOffset;
    logic [22:0] wordsLeft_r;  // Sectors times words per sector
    logic        segMode_r, lastSeg_r, reloadReq_r;
    logic        cmdWrite, inSeq, segAccept, discard;
    logic [7:0]  opcode;
    logic        ackPend;

    // =========================================================
    // Bus decode and command strobe
    assign ackPend  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmdWrite = ackPend && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_COMMAND);
    assign opcode   = wb_dat_i[7:0];
    assign xferLen  = {secNumR, secCntR};
    assign segOffset = {cylHiR, cylLoR};

    // Acknowledge and read data
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= ackPend;
            wb_dat_o <= 32'h0;
            if (ackPend && !wb_we_i) begin
                case (wb_adr_i)
                    OFS_FEATURE: wb_dat_o <= {24'h0, featR};
                    OFS_SECCNT:  wb_dat_o <= {24'h0, secCntR};
                    OFS_SECNUM:  wb_dat_o <= {24'h0, secNumR};
                    OFS_CYLLO:   wb_dat_o <= {24'h0, cylLoR};
                    OFS_CYLHI:   wb_dat_o <= {24'h0, cylHiR};
                    OFS_ERROR:   wb_dat_o <= {24'h0, errR};
                    OFS_STATUS:  wb_dat_o <= {24'h0, statusR};
                    default:     wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Task-file parameter registers, written only while not busy
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            featR   <= 8'h00;
            secCntR <= 8'h00;
            secNumR <= 8'h00;
            cylLoR  <= 8'h00;
            cylHiR  <= 8'h00;
        end else if (ackPend && wb_we_i && wb_sel_i[0] && !statusR[ST_BSY_BIT]) begin
            case (wb_adr_i)
                OFS_FEATURE: featR   <= wb_dat_i[7:0];
                OFS_SECCNT:  secCntR <= wb_dat_i[7:0];
                OFS_SECNUM:  secNumR <= wb_dat_i[7:0];
                OFS_CYLLO:   cylLoR  <= wb_dat_i[7:0];
                OFS_CYLHI:   cylHiR  <= wb_dat_i[7:0];
                default:     ;
            endcase
        end
    end

    // =========================================================
    // Segment sequencing
    assign segAccept = (state_r == S_IDLE) && !statusR[ST_BSY_BIT] && cmdWrite
                    && opcode == CMD_DOWNLOAD && featR == FEAT_SEGMENTED
                    && !securityLocked && inSeq;
    // Partial image dropped on other command, bad sequence, or reset
    assign discard = softReset
        || ((state_r == S_IDLE) && !statusR[ST_BSY_BIT] && cmdWrite
            && !(opcode == CMD_DOWNLOAD && featR == FEAT_SEGMENTED && inSeq));

    mdc_offset_check #(.W(16)) uOfs (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .clear      (discard || imageSave),
        .accept     (segAccept),
        .offset     (segOffset),
        .count      (xferLen),
        .inSequence (inSeq)
    );

    // =========================================================
    // Command state machine
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r        <= S_IDLE;
            errR           <= ERR_RESET;
            statusR        <= STATUS_RESET;
            wordsLeft_r    <= '0;
            segMode_r      <= 1'b0;
            lastSeg_r      <= 1'b0;
            reloadReq_r    <= 1'b0;
            imageDiscard   <= 1'b0;
            imageSave      <= 1'b0;
            reloadStart    <= 1'b0;
            diagStart      <= 1'b0;
            flushStart     <= 1'b0;
            spinDown       <= 1'b0;
            firmwareActive <= 1'b0;
            dataReady      <= 1'b0;
        end else begin
            imageDiscard <= discard;
            imageSave    <= 1'b0;
            reloadStart  <= 1'b0;
            diagStart    <= 1'b0;
            flushStart   <= 1'b0;
            if (softReset) begin
                state_r     <= S_IDLE;
                errR        <= ERR_RESET;
                statusR     <= STATUS_RESET;
                wordsLeft_r <= '0;
                dataReady   <= 1'b0;
                lastSeg_r   <= 1'b0;  // Stale final mark dropped
                reloadReq_r <= 1'b0;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (cmdWrite && !statusR[ST_BSY_BIT]) begin
                            statusR <= 8'h80;
                            errR    <= 8'h00;
                            // A new command forgets marks of an abandoned image
                            if (discard) begin
                                lastSeg_r   <= 1'b0;
                                reloadReq_r <= 1'b0;
                            end
                            case (opcode)
                                CMD_DOWNLOAD: begin
                                    if ((featR != FEAT_SEGMENTED && featR != FEAT_FULL)
                                        || securityLocked
                                        || (featR == FEAT_SEGMENTED && !inSeq)) begin
                                        errR[ERR_ABORT_BIT] <= 1'b1;
                                        statusR <= STATUS_RESET | 8'h01;
                                    end else if (xferLen == 16'h0) begin
                                        statusR <= STATUS_RESET;
                                    end else begin
                                        segMode_r   <= (featR == FEAT_SEGMENTED);
                                        wordsLeft_r <= 23'(xferLen) * 23'(SECTOR_WORDS);
                                        state_r     <= S_XFER;
                                        dataReady   <= 1'b1;
                                        statusR     <= 8'h88;
                                    end
                                end
                                CMD_DIAG: begin
                                    diagStart <= 1'b1;
                                    state_r   <= S_DIAG;
                                end
                                CMD_FLUSH: begin
                                    flushStart <= 1'b1;
                                    state_r    <= S_FLUSH;
                                end
                                default: begin
                                    errR[ERR_ABORT_BIT] <= 1'b1;
                                    statusR <= STATUS_RESET | 8'h01;
                                end
                            endcase
                        end
                    end
                    S_XFER: begin
                        if (dataValid && dataReady) begin
                            if (lastSegment)
                                lastSeg_r <= 1'b1;
                            if (reloadRequested)
                                reloadReq_r <= 1'b1;
                            wordsLeft_r <= wordsLeft_r - 23'h1;
                            if (wordsLeft_r == 23'h1) begin
                                dataReady <= 1'b0;
                                // Full download is always final
                                if (!segMode_r || lastSeg_r || lastSegment)
                                    state_r <= S_VERIFY;
                                else begin
                                    state_r <= S_IDLE;
                                    statusR <= STATUS_RESET;
                                end
                            end
                        end
                    end
                    S_VERIFY: begin
                        if (verifyDone) begin
                            lastSeg_r <= 1'b0;
                            if (!verifyOk) begin
                                reloadReq_r <= 1'b0;
                                errR[ERR_ABORT_BIT] <= 1'b1;
                                statusR <= STATUS_RESET | 8'h01;
                                state_r <= S_IDLE;
                            end else begin
                                imageSave <= 1'b1;
                                if (reloadReq_r) begin
                                    reloadStart <= 1'b1;
                                    state_r     <= S_RELOAD;
                                end else begin
                                    statusR <= STATUS_RESET;
                                    state_r <= S_IDLE;
                                end
                            end
                        end
                    end
                    S_RELOAD: begin
                        if (reloadDone) begin
                            reloadReq_r <= 1'b0;
                            state_r     <= S_IDLE;
                            if (reloadOk) begin
                                firmwareActive <= 1'b1;
                                spinDown <= spinupDisabled;
                                statusR  <= STATUS_RESET;
                            end else begin
                                errR[ERR_UNCORR_BIT] <= 1'b1;
                                statusR <= STATUS_RESET | 8'h01;
                            end
                        end
                    end
                    S_DIAG: begin
                        if (diagDone) begin
                            errR    <= diagCode;
                            statusR <= STATUS_RESET;
                            state_r <= S_IDLE;
                        end
                    end
                    S_FLUSH: begin
                        if (cacheEmpty) begin
                            statusR <= STATUS_RESET;
                            state_r <= S_IDLE;
                        end
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // =========================================================
    // Assertions
    AST_FLUSH_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == S_FLUSH && !cacheEmpty && !softReset) |=> statusR[ST_BSY_BIT])
        else $error("flush finished before cache empty");
    AST_ERR_STATUS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!statusR[ST_BSY_BIT] && (errR[ERR_ABORT_BIT] || errR[ERR_UNCORR_BIT])
         && state_r == S_IDLE && $changed(errR) && $past(state_r) != S_DIAG)
        |-> statusR[ST_ERR_BIT])
        else $error("error bit missing in status");
    AST_BAD_FEAT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (segAccept == 1'b0 && state_r == S_IDLE && !statusR[ST_BSY_BIT] && cmdWrite
         && opcode == CMD_DOWNLOAD && featR != FEAT_FULL && featR != FEAT_SEGMENTED
         && !softReset) |=> errR[ERR_ABORT_BIT])
        else $error("reserved feature not aborted");
    AST_DISCARD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        softReset |=> imageDiscard && state_r == S_IDLE)
        else $error("reset did not drop image");
    AST_RELOAD_UNC: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == S_RELOAD && reloadDone && !reloadOk && !softReset)
        |=> errR[ERR_UNCORR_BIT] && state_r == S_IDLE)
        else $error("failed reload not reported");
    AST_DIAG: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == S_DIAG && diagDone && !softReset) |=> errR == $past(diagCode))
        else $error("diagnostic code not loaded");
    AST_ZERO_LEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == S_IDLE && xferLen == 16'h0) |=> state_r != S_XFER)
        else $error("zero-length download moved data");
    AST_SPIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == S_RELOAD && reloadDone && reloadOk && spinupDisabled && !softReset)
        |=> spinDown && firmwareActive)
        else $error("no spin down after reload");
    // Data is taken only while a transfer is open
    AST_READY_XFER: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dataReady == (state_r == S_XFER))
        else $error("data ready outside transfer");
    // Out-of-sequence segment is refused and the image dropped
    AST_SEQ_ABORT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == S_IDLE && !statusR[ST_BSY_BIT] && cmdWrite && opcode == CMD_DOWNLOAD
         && featR == FEAT_SEGMENTED && !inSeq && !softReset)
        |=> errR[ERR_ABORT_BIT] && imageDiscard)
        else $error("out-of-sequence segment accepted");
    // Uncorrectable is only ever reported by a failed reload or a diagnostic code
    AST_UNC_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r != S_RELOAD && state_r != S_DIAG && !softReset && !errR[ERR_UNCORR_BIT])
        |=> !errR[ERR_UNCORR_BIT])
        else $error("uncorrectable set without reload");
endmodule
`default_nettype wire

/* mdc_host_model.sv */
// Host link model: streams sector data words into the command handler
`timescale 1ns/1ns
`default_nettype none
module mdc_host_model
    import mdc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        go,
    input  wire logic [15:0] sectors,
    input  wire logic        segLast,
    input  wire logic        wantReload,
    input  wire logic        slow,
    input  wire logic        dataReady,
    output logic             dataValid,
    output logic [31:0]      dataWord,
    output logic             lastSegment,
    output logic             reloadRequested,
    output logic             busy
);
    // =========================================================
    // Word counter, whole sectors only
    logic [23:0] left_r;
    logic [31:0] word_r;
    logic        phase_r;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            left_r  <= 24'h0;
            word_r  <= 32'h0;
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            if (go) begin
                left_r <= 24'(sectors) * 24'(SECTOR_WORDS);
            end else if (dataValid && dataReady) begin
                left_r <= left_r - 24'h1;
                word_r <= word_r + 32'h01010101;
            end
        end
    end
    // Stalls on alternate cycles when slow; idle data is inverted
    assign busy            = (left_r != 24'h0);
    assign dataValid       = busy && !(slow && phase_r);
    assign dataWord        = dataValid ? word_r : ~word_r;
    assign lastSegment     = dataValid && segLast;
    assign reloadRequested = dataValid && wantReload;
endmodule
`default_nettype wire

/* mdc_offset_check.sv */
// Segment offset sequencing tracker
`timescale 1ns/1ns
`default_nettype none
module mdc_offset_check
    import mdc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic         clear,
    input  wire logic         accept,
    input  wire logic [W-1:0] offset,
    input  wire logic [W-1:0] count,
    output logic              inSequence
);
    // A zero-width tracker cannot hold an offset
    if (W < 1) begin : gBadWidth
        $error("W must be at least 1");
    end

    logic [W-1:0] expect_r;
    logic         started_r;

    // =========================================================
    // Next expected offset tracking
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            expect_r  <= '0;
            started_r <= 1'b0;
        end else if (clear) begin
            expect_r  <= '0;
            started_r <= 1'b0;
        end else if (accept) begin
            expect_r  <= W'(offset + count);
            started_r <= 1'b1;
        end
    end

    // First segment must start at zero
    assign inSequence = started_r ? (offset == expect_r) : (offset == '0);
endmodule
`default_nettype wire

/* mdc_pkg.sv */
// Package of constants for the microcode download command handler
package mdc_pkg;
    // =========================================================
    // Command opcodes and feature codes
    localparam logic [7:0] CMD_DOWNLOAD   = 8'h92;
    localparam logic [7:0] CMD_DIAG       = 8'h90;
    localparam logic [7:0] CMD_FLUSH      = 8'he7;
    localparam logic [7:0] FEAT_SEGMENTED = 8'h03;
    localparam logic [7:0] FEAT_FULL      = 8'h07;
    // =========================================================
    // Register offsets (byte addresses)
    localparam logic [4:0] OFS_FEATURE  = 5'h00;
    localparam logic [4:0] OFS_SECCNT   = 5'h04;
    localparam logic [4:0] OFS_SECNUM   = 5'h08;
    localparam logic [4:0] OFS_CYLLO    = 5'h0c;
    localparam logic [4:0] OFS_CYLHI    = 5'h10;
    localparam logic [4:0] OFS_COMMAND  = 5'h14;
    localparam logic [4:0] OFS_ERROR    = 5'h18;
    localparam logic [4:0] OFS_STATUS   = 5'h1c;
    // =========================================================
    // Error and status bit positions
    localparam int ERR_ABORT_BIT  = 2;
    localparam int ERR_UNCORR_BIT = 6;
    localparam int ST_ERR_BIT     = 0;
    localparam int ST_DSC_BIT     = 4;
    localparam int ST_RDY_BIT     = 6;
    localparam int ST_BSY_BIT     = 7;
    // =========================================================
    // Reset values and sizes
    localparam logic [7:0] ERR_RESET    = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h50;
    localparam int SECTOR_BYTES   = 512;
    localparam int SECTOR_WORDS   = SECTOR_BYTES / 4;
endpackage

/* microcode_download_cmd_handler_tb.sv */
// Self-checking bench for the command handler
`timescale 1ns/1ns
`default_nettype none
module microcode_download_cmd_handler_tb
    import mdc_pkg::*;
;
    logic ref_clk = 1'b0, rst_b = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h0;
    logic [31:0] wdat = 32'h0, rdat, dWord;
    logic ack, dValid, dReady, lastSeg, relReq, hmBusy;
    logic secLock = 1'b0, spinOff = 1'b0, softRst = 1'b0;
    logic relOk = 1'b1, cacheEmpty = 1'b1, hmGo = 1'b0, hmLast = 1'b0;
    logic hmRel = 1'b0, slow = 1'b0;
    logic vOk = 1'b1;
    logic [3:0] sel = 4'h0;
    logic [7:0] dCode = 8'h81;
    logic [15:0] hmSec = 16'h0;
    logic discard, save, spinDown, fwActive, sawDiscard, sawSave;
    logic [7:0] rd;
    int n_errors = 0, samples_checked = 0;
    // =========================================================
    // Clock and design
    always #10 ref_clk = ~ref_clk;
    mdc_cmd_handler #(.IMAGE_SECTORS(16)) mdc_cmd_handler_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dataValid(dValid),
        .dataWord(dWord), .dataReady(dReady), .securityLocked(secLock),
        .spinupDisabled(spinOff), .softReset(softRst), .lastSegment(lastSeg),
        .reloadRequested(relReq), .verifyDone(1'b1), .verifyOk(vOk),
        .reloadDone(1'b1), .reloadOk(relOk), .diagDone(1'b1), .diagCode(dCode),
        .cacheEmpty(cacheEmpty), .imageDiscard(discard), .imageSave(save),
        .reloadStart(), .diagStart(), .flushStart(), .spinDown(spinDown),
        .firmwareActive(fwActive));
    mdc_host_model mdc_host_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .go(hmGo),
        .sectors(hmSec), .segLast(hmLast), .wantReload(hmRel), .slow(slow),
        .dataReady(dReady), .dataValid(dValid), .dataWord(dWord),
        .lastSegment(lastSeg), .reloadRequested(relReq), .busy(hmBusy));
    // Sticky capture of one-cycle pulses
    always @(posedge ref_clk) begin
        if (discard) sawDiscard <= 1'b1;
        if (save) sawSave <= 1'b1;
    end
    // =========================================================
    // Bus, compare and closing tasks
    task automatic wbAccess(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
        sel <= 4'h1;
        do @(posedge ref_clk); while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic waitIdle();
        do wbAccess(OFS_STATUS, 1'b0, 8'h0); while (rd[ST_BSY_BIT] !== 1'b0);
    endtask
    task automatic expRegs(input logic [7:0] st, input logic [7:0] er);
        wbAccess(OFS_STATUS, 1'b0, 8'h0); chk("status", st, rd);
        wbAccess(OFS_ERROR, 1'b0, 8'h0); chk("error", er, rd);
    endtask
    // One download command, optionally fed with its data
    task automatic dl(input logic [7:0] ft, input logic [15:0] ofs, input logic [15:0] n,
                      input logic last, input logic feed);
        sawDiscard <= 1'b0; sawSave <= 1'b0; hmLast <= last; hmSec <= n;
        wbAccess(OFS_FEATURE, 1'b1, ft);
        wbAccess(OFS_SECCNT, 1'b1, n[7:0]);
        wbAccess(OFS_SECNUM, 1'b1, n[15:8]);
        wbAccess(OFS_CYLLO, 1'b1, ofs[7:0]);
        wbAccess(OFS_CYLHI, 1'b1, ofs[15:8]);
        wbAccess(OFS_COMMAND, 1'b1, CMD_DOWNLOAD);
        if (feed) begin
            wbAccess(OFS_STATUS, 1'b0, 8'h0); chk("xfer status", 8'h88, rd);
            @(posedge ref_clk) hmGo <= 1'b1;
            @(posedge ref_clk) hmGo <= 1'b0;
            do @(posedge ref_clk); while (hmBusy);
        end
        waitIdle();
    endtask
    // =========================================================
    // Scenarios
    task automatic t_full();
        slow <= 1'b1; relOk <= 1'b0;
        dl(FEAT_FULL, 16'h0, 16'h2, 1'b0, 1'b1);
        expRegs(8'h50, 8'h00);
        chk("save", 8'h1, 8'(sawSave));
        slow <= 1'b0; hmRel <= 1'b1; relOk <= 1'b1; spinOff <= 1'b1;
        dl(FEAT_FULL, 16'h0, 16'h1, 1'b0, 1'b1);
        chk("spin down", 8'h1, 8'(spinDown));
        chk("active", 8'h1, 8'(fwActive));
        relOk <= 1'b0;
        dl(FEAT_FULL, 16'h0, 16'h1, 1'b0, 1'b1);
        expRegs(8'h51, 8'h40);
        hmRel <= 1'b0; spinOff <= 1'b0;
        $display("test full download done");
    endtask
    task automatic t_abort();
        dl(8'h05, 16'h0, 16'h1, 1'b0, 1'b0);
        expRegs(8'h51, 8'h04);
        secLock <= 1'b1;
        dl(FEAT_FULL, 16'h0, 16'h1, 1'b0, 1'b0);
        expRegs(8'h51, 8'h04);
        secLock <= 1'b0;
        dl(FEAT_FULL, 16'h0, 16'h0, 1'b0, 1'b0);
        chk("zero len ready", 8'h0, 8'(dReady));
        expRegs(8'h50, 8'h00);
        vOk <= 1'b0;
        dl(FEAT_FULL, 16'h0, 16'h1, 1'b0, 1'b1);
        expRegs(8'h51, 8'h04);
        chk("bad image save", 8'h0, 8'(sawSave));
        vOk <= 1'b1;
        $display("test abort done");
    endtask
    task automatic t_seg();
        dl(FEAT_SEGMENTED, 16'h0, 16'h1, 1'b0, 1'b1);
        expRegs(8'h50, 8'h00);
        dl(FEAT_SEGMENTED, 16'h1, 16'h1, 1'b1, 1'b1);
        chk("seg save", 8'h1, 8'(sawSave));
        dl(FEAT_SEGMENTED, 16'h0, 16'h2, 1'b0, 1'b1);
        dl(FEAT_SEGMENTED, 16'h0102, 16'h1, 1'b0, 1'b0);
        wbAccess(OFS_ERROR, 1'b0, 8'h0); chk("seq error", 8'h04, rd);
        chk("seq discard", 8'h1, 8'(sawDiscard));
        $display("test segments done");
    endtask
    task automatic t_other();
        dl(FEAT_SEGMENTED, 16'h0, 16'h1, 1'b0, 1'b1);
        cacheEmpty <= 1'b0;
        wbAccess(OFS_COMMAND, 1'b1, CMD_FLUSH);
        repeat (10) @(posedge ref_clk);
        wbAccess(OFS_STATUS, 1'b0, 8'h0); chk("flush busy", 8'h1, 8'(rd[ST_BSY_BIT]));
        cacheEmpty <= 1'b1;
        waitIdle();
        expRegs(8'h50, 8'h00);
        chk("other discard", 8'h1, 8'(sawDiscard));
        dCode <= 8'h3c;
        wbAccess(OFS_COMMAND, 1'b1, CMD_DIAG);
        waitIdle();
        wbAccess(OFS_ERROR, 1'b0, 8'h0); chk("diag code", 8'h3c, rd);
        expRegs(8'h50, 8'h3c);
        dl(FEAT_SEGMENTED, 16'h0, 16'h1, 1'b0, 1'b1);
        @(posedge ref_clk) softRst <= 1'b1;
        @(posedge ref_clk) softRst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("reset discard", 8'h1, 8'(sawDiscard));
        expRegs(STATUS_RESET, ERR_RESET);
        $display("test other commands done");
    endtask
    // =========================================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        expRegs(STATUS_RESET, ERR_RESET);
        t_full();
        t_abort();
        t_seg();
        t_other();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
